// ===== logic/fevp_flash_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fevp_flash_ctrl
   import fevp_pkg::*;
#(
   parameter int ADDR_W  = 16,
   parameter int BLOCKS  = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              porNrst,
   input  wire logic              standbyIn,
   // CPU register writes
   input  wire logic              ctrlFirstWr,
   input  wire logic [7:0]        ctrlFirstData,
   input  wire logic              ctrlSecondWr,
   input  wire logic [7:0]        ctrlSecondData,
   input  wire logic              blockSelWr,
   input  wire logic [BLOCKS-1:0] blockSelData,
   // CPU flash access
   input  wire logic              flashWr,
   input  wire logic              flashRd,
   input  wire logic [ADDR_W-1:0] flashAddr,
   input  wire logic [7:0]        flashWrData,
   // Malfunction sources
   input  wire logic              exceptionStart,
   input  wire logic              sleepExec,
   input  wire logic              busRelease,
   // Flash array side
   input  wire logic [15:0]       arrayRdData,
   output logic [ADDR_W-1:0]      arrayAddr,
   output logic [BLOCKS-1:0]      arrayEraseBlocks,
   output logic                   arrayProgram,
   output logic                   arrayErase,
   output logic                   arrayVerify,
   // CPU view
   output logic [7:0]             flashCtrlFirst,
   output logic [7:0]             flashCtrlSecond,
   output logic [BLOCKS-1:0]      blockSelectReg,
   output logic [15:0]            flashRdData,
   output logic                   flashError
);
   logic              standbySync;
   logic [7:0]        fc1_reg, fc1_next;
   logic [7:0]        fc2_reg, fc2_next;
   logic [BLOCKS-1:0] bsel_reg, bsel_next;
   logic              flash_error_flag_reg, flash_error_flag_next;
   fevp_mode_e        mode_reg, mode_next;
   logic [ADDR_W-1:0] latch_reg, latch_next;
   logic [15:0]       rd_reg, rd_next;
   logic [BLOCKS-1:0] ebk_reg, ebk_next;
   logic              prg_reg, prg_next;
   logic              ers_reg, ers_next;
   logic              vfy_reg, vfy_next;
   logic              active;
   logic              malfunction;
   logic              runAllowed;

   fevp_sync3 u_standby_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .din     (standbyIn),
      .dout    (standbySync)
   );

   // Malfunction only counts while program or erase really runs
   // Verify reads must not trip the flag, hence the mode gate.
   // A fault source in setup mode is harmless and ignored.
   always_comb begin
      active      = (mode_reg == FEVP_PROG) || (mode_reg == FEVP_ERASE);
      malfunction = active && (flashRd || exceptionStart || sleepExec || busRelease);
      runAllowed  = fc1_reg[FC1_SWE] && !flash_error_flag_reg && (bsel_reg != '0);
   end

   // Register writes; standby initialises like a reset
   always_comb begin
      fc1_next  = fc1_reg;
      fc2_next  = fc2_reg;
      bsel_next = bsel_reg;
      if (standbySync) begin
         fc1_next  = FC1_RESET;
         fc2_next  = FC2_RESET;
         bsel_next = BSEL_RESET;
      end else begin
         if (ctrlFirstWr) begin
            fc1_next = ctrlFirstData;
         end
         if (ctrlSecondWr) begin
            fc2_next[FC2_ESU] = ctrlSecondData[FC2_ESU];
            fc2_next[FC2_PSU] = ctrlSecondData[FC2_PSU];
         end
         if (blockSelWr) begin
            bsel_next = blockSelData;
         end
      end
   end

   // Error flag: set by hardware only, survives all but power-on
   always_comb begin
      flash_error_flag_next = flash_error_flag_reg | malfunction;
   end

   // Mode sequencer
   // Verify outranks run so error protection still reaches verify mode.
   // Standby overrides everything, as a reset would.
   // No wait time is timed here; software owns every delay
   // Trade-off: a too-early run bit is obeyed, the watchdog is the guard.
   always_comb begin
      mode_next = FEVP_IDLE;
      if (malfunction) begin
         mode_next = (fc1_reg[FC1_EV] || fc1_reg[FC1_PV]) ? FEVP_VERIFY : FEVP_IDLE;
      end else if (fc1_reg[FC1_EV] || fc1_reg[FC1_PV]) begin
         mode_next = FEVP_VERIFY;
      end else if (runAllowed && fc2_reg[FC2_ESU] && fc1_reg[FC1_E]) begin
         mode_next = FEVP_ERASE;
      end else if (runAllowed && fc2_reg[FC2_PSU] && fc1_reg[FC1_P]) begin
         mode_next = FEVP_PROG;
      end else if (fc2_reg[FC2_ESU]) begin
         mode_next = FEVP_ESETUP;
      end else if (fc2_reg[FC2_PSU]) begin
         mode_next = FEVP_PSETUP;
      end
      if (standbySync) begin
         mode_next = FEVP_IDLE;
      end
   end

   // Array drive; erase touches selected blocks only, no preprogram pass
   always_comb begin
      ebk_next = (mode_next == FEVP_ERASE) ? bsel_reg : '0;
      ers_next = (mode_next == FEVP_ERASE);
      prg_next = (mode_next == FEVP_PROG);
      vfy_next = (mode_next == FEVP_VERIFY);
   end

   // Dummy write latches verify address; read returns array word, or ERASED_WORD when FC1_SWE is set outside verify
   always_comb begin
      latch_next = latch_reg;
      rd_next    = rd_reg;
      if (flashWr && (mode_reg == FEVP_VERIFY) && (flashWrData == DUMMY_BYTE)) begin
         latch_next = flashAddr;
      end
      if (flashRd) begin
         if (mode_reg == FEVP_VERIFY) begin
            rd_next = arrayRdData;
         end else if (fc1_reg[FC1_SWE]) begin
            rd_next = ERASED_WORD;                                // not valid data
         end else begin
            rd_next = arrayRdData;
         end
      end
   end

   // Plain reset clears control state but never the error flag
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fc1_reg   <= FC1_RESET;
         fc2_reg   <= FC2_RESET;
         bsel_reg  <= BSEL_RESET;
         mode_reg  <= FEVP_IDLE;
         latch_reg <= '0;
         rd_reg    <= 16'h0000;
         ebk_reg   <= '0;
         prg_reg   <= 1'b0;
         ers_reg   <= 1'b0;
         vfy_reg   <= 1'b0;
      end else begin
         fc1_reg   <= fc1_next;
         fc2_reg   <= fc2_next;
         bsel_reg  <= bsel_next;
         mode_reg  <= mode_next;
         latch_reg <= latch_next;
         rd_reg    <= rd_next;
         ebk_reg   <= ebk_next;
         prg_reg   <= prg_next;
         ers_reg   <= ers_next;
         vfy_reg   <= vfy_next;
      end
   end

   // Separate power-on domain for the error flag
   always_ff @(posedge clk_sys or negedge porNrst) begin
      if (!porNrst) begin
         flash_error_flag_reg <= 1'b0;
      end else begin
         flash_error_flag_reg <= flash_error_flag_next;
      end
   end

   assign arrayAddr        = latch_reg;
   assign arrayEraseBlocks = ebk_reg;
   assign arrayProgram     = prg_reg;
   assign arrayErase       = ers_reg;
   assign arrayVerify      = vfy_reg;
   assign flashCtrlFirst   = fc1_reg;
   assign flashCtrlSecond  = {flash_error_flag_reg, fc2_reg[6:0]};
   assign blockSelectReg   = bsel_reg;
   assign flashRdData      = rd_reg;
   assign flashError       = flash_error_flag_reg;
endmodule
`default_nettype wire

// ===== include/fevp_pkg.sv
package fevp_pkg;
   // First control register field positions
   localparam int FC1_SWE = 6;
   localparam int FC1_ESU_UNUSED = 0;
   localparam int FC1_EV  = 3;
   localparam int FC1_PV  = 2;
   localparam int FC1_E   = 1;
   localparam int FC1_P   = 0;
   // Second control register field positions
   localparam int FC2_FLASH_ERROR_FLAG = 7;
   localparam int FC2_ESU  = 1;
   localparam int FC2_PSU  = 0;
   // Reset values
   localparam logic [7:0] FC1_RESET = 8'h00;
   localparam logic [7:0] FC2_RESET = 8'h00;
   localparam logic [7:0] BSEL_RESET = 8'h00;
   // Erased data pattern and verify dummy-write byte
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [7:0]  DUMMY_BYTE  = 8'hff;
   // Flash operating modes
   typedef enum logic [5:0] {
      FEVP_IDLE   = 6'b000001,
      FEVP_PSETUP = 6'b000010,
      FEVP_ESETUP = 6'b000100,
      FEVP_PROG   = 6'b001000,
      FEVP_ERASE  = 6'b010000,
      FEVP_VERIFY = 6'b100000
   } fevp_mode_e;
endpackage

// ===== logic/fevp_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; level accepted once stages two and three agree
module fevp_sync3 (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       out_reg;
   logic       out_next;

   // Shift and agreement filter
   always_comb begin
      stage_next = {stage_reg[1:0], din};
      out_next   = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : out_reg;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage_reg <= 3'h0;
         out_reg   <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         out_reg   <= out_next;
      end
   end

   assign dout = out_reg;
endmodule
`default_nettype wire

// ===== bench/fevp_flash_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port watcher for the flash sequencer
module fevp_flash_ctrl_monitor
   import fevp_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int BLOCKS = 8
) (
   input wire logic              clk_sys,
   input wire logic              nrst,
   input wire logic              porNrst,
   input wire logic              flashWr,
   input wire logic              flashRd,
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic [7:0]        flashWrData,
   input wire logic              exceptionStart,
   input wire logic              sleepExec,
   input wire logic              busRelease,
   input wire logic [15:0]       arrayRdData,
   input wire logic [ADDR_W-1:0] arrayAddr,
   input wire logic [BLOCKS-1:0] arrayEraseBlocks,
   input wire logic              arrayProgram,
   input wire logic              arrayErase,
   input wire logic              arrayVerify,
   input wire logic [7:0]        flashCtrlFirst,
   input wire logic [7:0]        flashCtrlSecond,
   input wire logic [BLOCKS-1:0] blockSelectReg,
   input wire logic [15:0]       flashRdData,
   input wire logic              flashError
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Erase request fully armed, and no fault source active
   sequence erase_req;
      flashCtrlFirst[FC1_SWE] && flashCtrlFirst[FC1_E] && flashCtrlSecond[FC2_ESU] && |blockSelectReg && !flashError;
   endsequence
   sequence quiet;
      !flashRd && !exceptionStart && !sleepExec && !busRelease;
   endsequence
   erase_start_a: assert property (erase_req ##0 quiet |=> arrayErase && arrayEraseBlocks == $past(blockSelectReg))
      else $error("erase not started on armed block");
   swe_guard_a: assert property (!flashCtrlFirst[FC1_SWE] |=> !arrayErase && !arrayProgram)
      else $error("array busy without write enable");
   sel_guard_a: assert property (blockSelectReg == '0 |=> !arrayErase && !arrayProgram)
      else $error("array busy with empty selection");
   // Own disable: reset itself is what is checked here
   reset_clear_a: assert property (disable iff (1'b0) !nrst |-> flashCtrlFirst == '0 && blockSelectReg == '0 && !arrayErase)
      else $error("registers not cleared in reset");
   read_abort_a: assert property (arrayErase && flashRd |=> flashError && !arrayErase)
      else $error("read during erase not aborted");
   fault_flag_a: assert property ((arrayErase || arrayProgram) && (exceptionStart || sleepExec || busRelease) |=> flashError)
      else $error("fault source did not raise error");
   err_sticky_a: assert property (@(posedge clk_sys) disable iff (!porNrst) flashError |=> flashError)
      else $error("error flag lost without power-on reset");
   err_lock_a: assert property (flashError |=> !arrayErase && !arrayProgram)
      else $error("run mode entered under error protection");
   verify_ok_a: assert property (flashCtrlFirst[FC1_SWE] && flashCtrlFirst[FC1_EV] && !flashCtrlFirst[FC1_E]
      && !flashCtrlFirst[FC1_P] |=> arrayVerify)
      else $error("verify mode not entered");
   dummy_latch_a: assert property (arrayVerify && flashWr && flashWrData == DUMMY_BYTE |=> arrayAddr == $past(flashAddr))
      else $error("dummy write address not latched");
   verify_read_a: assert property (arrayVerify && flashRd |=> flashRdData == $past(arrayRdData))
      else $error("verify word not returned");
endmodule
bind fevp_flash_ctrl fevp_flash_ctrl_monitor #(.ADDR_W(ADDR_W), .BLOCKS(BLOCKS)) u_mon (.*);
`default_nettype wire

// ===== bench/flash_erase_verify_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_verify_protect_tb
   import fevp_pkg::*;
;
   localparam logic [7:0] SW_WRITE_ENABLE = 8'h01 << FC1_SWE;
   localparam logic [7:0] ER  = 8'h01 << FC1_E;
   localparam logic [7:0] EV  = 8'h01 << FC1_EV;
   localparam logic [7:0] ERASE_SETUP_BIT = 8'h01 << FC2_ESU;
   localparam logic [7:0] PROGRAM_SETUP_BIT = 8'h01 << FC2_PSU;
   localparam logic [7:0] PR  = 8'h01 << FC1_P;
   logic        clk_sys, nrst, porNrst, standbyIn, ctrlFirstWr, ctrlSecondWr, blockSelWr, flashWr, flashRd;
   logic        exceptionStart, sleepExec, busRelease, arrayProgram, arrayErase, arrayVerify, flashError;
   logic [7:0]  ctrlFirstData, ctrlSecondData, blockSelData, flashWrData;
   logic [7:0]  flashCtrlFirst, flashCtrlSecond, blockSelectReg, arrayEraseBlocks;
   logic [15:0] flashAddr, arrayRdData, arrayAddr, flashRdData;
   int          nErrors, samplesChecked;
   fevp_flash_ctrl dut (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Inputs move 1 ns after the edge so sampling never races
   task automatic cyc(int n = 1);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   // k: 0 first control, 1 second control, 2 block select
   task automatic wr(int k, logic [7:0] d);
      {ctrlFirstData, ctrlSecondData, blockSelData} = {3{d}};
      {blockSelWr, ctrlSecondWr, ctrlFirstWr} = 3'h1 << k;
      cyc();
      {blockSelWr, ctrlSecondWr, ctrlFirstWr} = 3'h0;
   endtask
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", samplesChecked, nErrors);
      if (nErrors == 0 && samplesChecked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Run bit without enable, then enable with no block chosen
   task automatic s_guard;
      wr(1, ERASE_SETUP_BIT);
      wr(0, ER);
      cyc();
      chk(arrayErase, 16'h0);
      chk(arrayProgram, 16'h0);
      wr(0, SW_WRITE_ENABLE | ER);
      cyc();
      chk(arrayErase, 16'h0);
      wr(0, 8'h00);
      // Program mode reached through the other setup bit
      wr(2, 8'h01);
      wr(1, PROGRAM_SETUP_BIT);
      wr(0, SW_WRITE_ENABLE | PR);
      cyc();
      chk(arrayProgram, 16'h1);
      chk(arrayErase, 16'h0);
      wr(0, 8'h00);
      wr(1, ERASE_SETUP_BIT);
      wr(2, 8'h00);
   endtask
   // Full erase pass, verify of one word, then standby wipe
   task automatic s_erase;
      int i;
      wr(2, 8'h05);
      // Watchdog arming belongs to software outside this block
      wr(0, SW_WRITE_ENABLE | ER);
      cyc();
      chk(arrayErase, 16'h1);
      chk(arrayEraseBlocks, 16'h5);
      wr(0, SW_WRITE_ENABLE);
      wr(1, 8'h00);
      // Array word is not erased; read with write enable outside verify
      arrayRdData = 16'h00f0;
      flashRd = 1'b1;
      cyc();
      flashRd = 1'b0;
      chk(flashRdData, ERASED_WORD);
      wr(0, SW_WRITE_ENABLE | EV);
      cyc();
      {flashAddr, flashWrData, flashWr} = {16'h0123, DUMMY_BYTE, 1'b1};
      cyc();
      flashWr = 1'b0;
      chk(arrayAddr, 16'h0123);
      flashRd = 1'b1;
      cyc();
      flashRd = 1'b0;
      chk(flashRdData, 16'h00f0);
      arrayRdData = ERASED_WORD;
      chk(flashError, 16'h0);
      wr(0, SW_WRITE_ENABLE);
      cyc();
      chk(arrayVerify, 16'h0);
      // Wait times are software parameters, not modelled here
      standbyIn = 1'b1;
      for (i = 0; i < 10 && flashCtrlFirst !== 8'h00; i++) cyc();
      chk(blockSelectReg, 16'h0);
      chk(flashCtrlFirst, 16'h0);
      standbyIn = 1'b0;
      cyc(5);
   endtask
   // Read during erase trips protection; only power-on reset clears it
   task automatic s_error;
      wr(2, 8'h80);
      wr(1, ERASE_SETUP_BIT);
      wr(0, SW_WRITE_ENABLE | ER);
      cyc();
      flashRd = 1'b1;
      cyc();
      flashRd = 1'b0;
      chk(flashError, 16'h1);
      chk(arrayErase, 16'h0);
      chk(flashCtrlFirst, SW_WRITE_ENABLE | ER);
      chk(blockSelectReg, 16'h80);
      wr(0, SW_WRITE_ENABLE);
      wr(0, SW_WRITE_ENABLE | ER);
      cyc();
      chk(arrayErase, 16'h0);
      wr(0, SW_WRITE_ENABLE | EV);
      cyc();
      chk(arrayVerify, 16'h1);
      nrst = 1'b0;
      cyc();
      nrst = 1'b1;
      chk(flashError, 16'h1);
      chk(flashCtrlFirst, 16'h0);
      {nrst, porNrst} = 2'b00;
      cyc();
      {nrst, porNrst} = 2'b11;
      chk(flashError, 16'h0);
   endtask
   initial begin
      {nrst, porNrst, standbyIn, ctrlFirstWr, ctrlSecondWr, blockSelWr, flashWr, flashRd} = '0;
      {exceptionStart, sleepExec, busRelease} = '0;
      {ctrlFirstData, ctrlSecondData, blockSelData, flashWrData, flashAddr} = '0;
      arrayRdData = ERASED_WORD;
      nErrors = 0;
      samplesChecked = 0;
      cyc(3);
      {nrst, porNrst} = 2'b11;
      chk(flashCtrlSecond, 16'h0);
      s_guard();
      s_erase();
      s_error();
      give_verdict();
   end
endmodule
`default_nettype wire
